/* File: src/cst_timer.sv */
/*
 * Cascaded sixteen-bit timer/counter with APB register access.
 * Assumes the event pin is synchronous to clk_i and APB signals follow
 * the usual setup and access phases.
 */
`timescale 1ns/1ps
// Functional notes
// RULE_01: Timer mode counts taps, clears on period match.
// RULE_02: Software writes period low then high.
// RULE_03: Period register unbuffered in timer/event modes.
// RULE_04: Software keeps flop initial value zero.
// RULE_05: Event mode counts pin falling edges.
// RULE_06: Event pin levels last two machine cycles.
// RULE_07: PWM toggles on duty match and overflow.
// RULE_08: Pulse pins drive inverse of output flop.
// RULE_09: Initial-value bit presets flop; reset clears.
// RULE_10: PWM duty buffered, transferred at interrupt.
// RULE_11: Duty reads return the active shift stage.
// RULE_12: Software writes duty right after interrupt.
// RULE_13: Stopped pin holds; preset only after stop.
// RULE_14: Software stops counter before STOP mode.
// RULE_15: PPG toggles on duty and period match.
// RULE_16: PPG duty and period writes act immediately.
// RULE_17: Software writes PPG registers low then high.
// RULE_18: Software sets port output latch to one.
// RULE_19: Four prescaled taps, prescale select halves each.
// RULE_20: Low byte carries into high byte counter.
module cst_timer (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic event_input_pin_i,
	output logic pwm_output_pin_o,
	output logic pulse_gen_output_pin_o,
	output logic upper_match_irq_o
);
	cst_pkg::cst_state_t s_r;
	cst_pkg::cst_state_t s_nxt;
	cst_pkg::cst_mode_t mode;
	logic run;
	logic [3:0] tap_exp;
	logic [11:0] tap_mask;
	logic tick;
	logic fall;
	logic cen;
	logic [15:0] cnt_inc;
	logic acc;
	logic wr;
	logic mapped;

	//////////////////////////////////////////////////////////////////////
	// Clock source: free divider taps or the event pin's falling edge.
	always_comb begin
		unique case (s_r.lower_ctrl[cst_pkg::TAP_LSB +: 2])
			2'h0: tap_exp = cst_pkg::TAP0_EXP; // [RULE_19]
			2'h1: tap_exp = cst_pkg::TAP1_EXP;
			2'h2: tap_exp = cst_pkg::TAP2_EXP;
			2'h3: tap_exp = cst_pkg::TAP3_EXP;
		endcase
		tap_exp = tap_exp + {3'h0, s_r.lower_ctrl[cst_pkg::PRESCALE_SELECT_BIT]}; // [RULE_19]
	end
	assign tap_mask = ~(12'hFFF << tap_exp);
	assign tick = (s_r.div & tap_mask) == tap_mask;
	assign fall = s_r.ev_prev & ~event_input_pin_i; // [RULE_05]
	assign mode = cst_pkg::cst_mode_t'(s_r.upper_ctrl[cst_pkg::MODE_LSB +: 2]);
	assign run = s_r.upper_ctrl[cst_pkg::RUN_BIT];
	// Event mode always counts the pin; other modes may pick it instead of a tap.
	assign cen = run & ((mode == cst_pkg::CST_EVENT
		|| s_r.lower_ctrl[cst_pkg::EXT_CLK_BIT]) ? fall : tick);
	assign cnt_inc = s_r.cnt + 16'h0001; // [RULE_20]

	// APB decode; the slave never inserts wait states.
	assign acc = psel_i & penable_i;
	assign wr = acc & pwrite_i;
	assign mapped = paddr_i[1:0] == 2'h0 && paddr_i <= cst_pkg::COUNT_OFS;

	//////////////////////////////////////////////////////////////////////
	// Next state: counting, compare actions, then register writes.
	always_comb begin
		s_nxt = s_r;
		s_nxt.div = s_r.div + 12'h001;
		s_nxt.ev_prev = event_input_pin_i;
		s_nxt.irq = 1'b0;
		if (!run) begin
			s_nxt.cnt = 16'h0000;
		end else if (cen) begin
			unique case (mode)
				cst_pkg::CST_TIMER, cst_pkg::CST_EVENT: begin
					if (cnt_inc == s_r.period) begin // [RULE_01] [RULE_05]
						s_nxt.cnt = 16'h0000;
						s_nxt.irq = 1'b1;
					end else begin
						s_nxt.cnt = cnt_inc;
					end
				end
				cst_pkg::CST_PWM: begin
					if (&s_r.cnt) begin // [RULE_07]
						s_nxt.cnt = 16'h0000;
						s_nxt.flop = ~s_r.flop;
						s_nxt.irq = 1'b1;
						s_nxt.duty_act = s_r.duty_buf; // [RULE_10]
					end else begin
						s_nxt.cnt = cnt_inc;
						if (cnt_inc == s_r.duty_act) begin // [RULE_07]
							s_nxt.flop = ~s_r.flop;
						end
					end
				end
				cst_pkg::CST_PPG: begin
					if (cnt_inc == s_r.period) begin // [RULE_15]
						s_nxt.cnt = 16'h0000;
						s_nxt.flop = ~s_r.flop;
						s_nxt.irq = 1'b1;
					end else begin
						s_nxt.cnt = cnt_inc;
						if (cnt_inc == s_r.duty_act) begin // [RULE_15]
							s_nxt.flop = ~s_r.flop;
						end
					end
				end
			endcase
		end
		// Register writes take effect in the access phase.
		if (wr) begin
			unique case (paddr_i)
				cst_pkg::LOWER_CTRL_OFS: begin
					s_nxt.lower_ctrl = pwdata_i[7:0];
				end
				cst_pkg::UPPER_CTRL_OFS: begin
					s_nxt.upper_ctrl = pwdata_i[7:0];
					// A write while running (including the stopping one) leaves the flop alone.
					if (!run) begin // [RULE_13]
						s_nxt.flop = pwdata_i[cst_pkg::FLOP_INITIAL_VALUE_BIT]; // [RULE_09]
					end
				end
				cst_pkg::PERIOD_LO_OFS: begin
					s_nxt.period[7:0] = pwdata_i[7:0]; // [RULE_03] [RULE_16]
				end
				cst_pkg::PERIOD_HI_OFS: begin
					s_nxt.period[15:8] = pwdata_i[7:0]; // [RULE_03] [RULE_16]
				end
				cst_pkg::DUTY_LO_OFS: begin
					s_nxt.duty_buf[7:0] = pwdata_i[7:0];
				end
				cst_pkg::DUTY_HI_OFS: begin
					s_nxt.duty_buf[15:8] = pwdata_i[7:0];
				end
				default: begin
				end
			endcase
			// Outside a running PWM the duty passes straight to the compare.
			if ((paddr_i == cst_pkg::DUTY_LO_OFS || paddr_i == cst_pkg::DUTY_HI_OFS)
				&& !(run && mode == cst_pkg::CST_PWM)) begin // [RULE_10] [RULE_16]
				s_nxt.duty_act = s_nxt.duty_buf;
			end
		end
		// Read data is captured in the setup phase.
		if (psel_i && !penable_i) begin
			unique case (paddr_i)
				cst_pkg::LOWER_CTRL_OFS: s_nxt.rdata = {24'h000000, s_r.lower_ctrl};
				cst_pkg::UPPER_CTRL_OFS: s_nxt.rdata = {24'h000000, s_r.upper_ctrl};
				cst_pkg::PERIOD_LO_OFS: s_nxt.rdata = {24'h000000, s_r.period[7:0]};
				cst_pkg::PERIOD_HI_OFS: s_nxt.rdata = {24'h000000, s_r.period[15:8]};
				cst_pkg::DUTY_LO_OFS: s_nxt.rdata = {24'h000000, s_r.duty_act[7:0]}; // [RULE_11]
				cst_pkg::DUTY_HI_OFS: s_nxt.rdata = {24'h000000, s_r.duty_act[15:8]}; // [RULE_11]
				cst_pkg::COUNT_OFS: s_nxt.rdata = {16'h0000, s_r.cnt};
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// State register; reset clears the output flop.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_r.div <= 12'h000;
			s_r.ev_prev <= 1'b1;
			s_r.cnt <= 16'h0000;
			s_r.period <= cst_pkg::COMPARE_RESET;
			s_r.duty_buf <= cst_pkg::COMPARE_RESET;
			s_r.duty_act <= cst_pkg::COMPARE_RESET;
			s_r.lower_ctrl <= cst_pkg::CTRL_RESET;
			s_r.upper_ctrl <= cst_pkg::CTRL_RESET;
			s_r.flop <= 1'b0; // [RULE_09]
			s_r.irq <= 1'b0;
			s_r.rdata <= 32'h00000000;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs: pins idle high outside their own mode.
	assign prdata_o = s_r.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = acc & ~mapped;
	assign upper_match_irq_o = s_r.irq;
	assign pwm_output_pin_o = (mode == cst_pkg::CST_PWM) ? ~s_r.flop : 1'b1; // [RULE_08]
	assign pulse_gen_output_pin_o = (mode == cst_pkg::CST_PPG) ? ~s_r.flop : 1'b1; // [RULE_08]

	//////////////////////////////////////////////////////////////////////
	// Checks on the counting and output behaviour.
	// A stopped flop may still be preset by the very next write, so the hold
	// check looks one cycle ahead only.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_period_hit;
		cen && (mode == cst_pkg::CST_TIMER || mode == cst_pkg::CST_EVENT)
			&& cnt_inc == s_r.period && !wr;
	endsequence
	sequence s_cleared_irq;
		s_r.cnt == 16'h0000 && upper_match_irq_o;
	endsequence
	property p_timer_match;
		s_period_hit |=> s_cleared_irq;
	endproperty
	a_timer_match: assert property (p_timer_match) else $error("no clear on period match"); // [RULE_01]

	property p_event_count;
		run && mode == cst_pkg::CST_EVENT && fall && cnt_inc != s_r.period
			|=> s_r.cnt == $past(cnt_inc) && !upper_match_irq_o;
	endproperty
	a_event_count: assert property (p_event_count) else $error("edge not counted"); // [RULE_05]

	property p_pwm_overflow;
		cen && mode == cst_pkg::CST_PWM && &s_r.cnt && !wr
			|=> s_r.flop != $past(s_r.flop) && s_r.duty_act == $past(s_r.duty_buf)
			##0 s_cleared_irq;
	endproperty
	a_pwm_overflow: assert property (p_pwm_overflow) else $error("bad PWM overflow"); // [RULE_07]

	property p_pin_inverse;
		mode == cst_pkg::CST_PWM |-> pwm_output_pin_o == ~s_r.flop && pulse_gen_output_pin_o;
	endproperty
	a_pin_inverse: assert property (p_pin_inverse) else $error("PWM pin not inverse"); // [RULE_08]

	property p_preset;
		wr && paddr_i == cst_pkg::UPPER_CTRL_OFS && !run
			|=> s_r.flop == $past(pwdata_i[cst_pkg::FLOP_INITIAL_VALUE_BIT]);
	endproperty
	a_preset: assert property (p_preset) else $error("flop not preset"); // [RULE_09]

	property p_duty_hold;
		run && mode == cst_pkg::CST_PWM && !upper_match_irq_o ##1 !upper_match_irq_o
			|-> $stable(s_r.duty_act);
	endproperty
	a_duty_hold: assert property (p_duty_hold) else $error("duty moved early"); // [RULE_10]

	property p_stop_hold;
		!run && !wr |=> $stable(s_r.flop);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("flop moved when stopped"); // [RULE_13]

	property p_ppg_period;
		cen && mode == cst_pkg::CST_PPG && cnt_inc == s_r.period && !wr
			|=> s_r.flop != $past(s_r.flop) ##0 s_cleared_irq;
	endproperty
	a_ppg_period: assert property (p_ppg_period) else $error("bad PPG period match"); // [RULE_15]

	property p_ppg_duty_now;
		wr && paddr_i == cst_pkg::DUTY_LO_OFS && mode == cst_pkg::CST_PPG
			|=> s_r.duty_act[7:0] == $past(pwdata_i[7:0]);
	endproperty
	a_ppg_duty_now: assert property (p_ppg_duty_now) else $error("PPG duty delayed"); // [RULE_16]
endmodule

/* File: src/cst_pkg.sv */
/*
 * Package of the cascaded sixteen-bit timer: register offsets, field
 * positions, prescaler taps, modes and the state record of the block.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
package cst_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [7:0] LOWER_CTRL_OFS = 8'h00;
	localparam logic [7:0] UPPER_CTRL_OFS = 8'h04;
	localparam logic [7:0] PERIOD_LO_OFS = 8'h08;
	localparam logic [7:0] PERIOD_HI_OFS = 8'h0C;
	localparam logic [7:0] DUTY_LO_OFS = 8'h10;
	localparam logic [7:0] DUTY_HI_OFS = 8'h14;
	localparam logic [7:0] COUNT_OFS = 8'h18;
	// Field positions in the lower channel control register.
	localparam int TAP_LSB = 0;
	localparam int EXT_CLK_BIT = 2;
	localparam int PRESCALE_SELECT_BIT = 3;
	// Field positions in the upper channel control register.
	localparam int MODE_LSB = 0;
	localparam int RUN_BIT = 3;
	localparam int FLOP_INITIAL_VALUE_BIT = 7;
	// Divider exponents of the four internal taps, prescale select off.
	localparam logic [3:0] TAP0_EXP = 4'hB;
	localparam logic [3:0] TAP1_EXP = 4'h7;
	localparam logic [3:0] TAP2_EXP = 4'h5;
	localparam logic [3:0] TAP3_EXP = 4'h3;
	// Values after reset.
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COMPARE_RESET = 16'hFFFF;

	typedef enum logic [1:0] {
		CST_TIMER,
		CST_EVENT,
		CST_PWM,
		CST_PPG
	} cst_mode_t;

	typedef struct packed {
		logic [11:0] div;
		logic ev_prev;
		logic [15:0] cnt;
		logic [15:0] period;
		logic [15:0] duty_buf;
		logic [15:0] duty_act;
		logic [7:0] lower_ctrl;
		logic [7:0] upper_ctrl;
		logic flop;
		logic irq;
		logic [31:0] rdata;
	} cst_state_t;
endpackage

/* File: tb/testbench.sv */
/*
 * Self-checking bench of the cascaded sixteen-bit timer: APB register
 * access, timer, event, PWM and PPG modes, checked at the pins.
 * Assumes the design answers APB with no wait states and a 125 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", nm, ex, got); end end

module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic ev_pin = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, pwm_pin, ppg_pin, irq;
	logic [2:0] obs;
	logic [32:0] exp_q[$];
	logic [32:0] mon_e;
	logic [3:0] taps[4];
	int error_cnt = 0, checked = 0, cyc = 0, irq_cnt = 0, seed = 89, t0, t1;

	////////////////////////////////////////////////////////////////////////
	// Clock, device and the observed pin vector.
	always #4 clk = ~clk;
	assign obs = {ppg_pin, pwm_pin, irq};
	cst_timer u_dut (.clk_i(clk), .reset_i(rst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .event_input_pin_i(ev_pin),
		.pwm_output_pin_o(pwm_pin), .pulse_gen_output_pin_o(ppg_pin),
		.upper_match_irq_o(irq));

	// Cycle count, interrupt count and the bus monitor that takes the oldest note.
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) begin
		if (irq === 1'b1) irq_cnt++;
		if (psel && penable && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			`CHK("pslverr", mon_e[32], pslverr)
			if (!pwrite) `CHK("prdata", mon_e[31:0], prdata)
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ends the run with the counts and the verdict.
	task report_and_stop;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h000000, d};
		exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin error_cnt++; report_and_stop(); end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h000000000);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] v);
		apb(1'b0, a, 8'h00, {1'b0, v});
	endtask

	// Waits, bounded, for one observed pin to reach a level; t1 gets the cycle.
	task waitv(input int sel, input logic lvl);
		int n;
		n = 0;
		do begin @(negedge clk); n++; end while (obs[sel] !== lvl && n < 10000);
		if (n >= 10000) begin error_cnt++; report_and_stop(); end
		t1 = cyc;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		taps = '{cst_pkg::TAP0_EXP, cst_pkg::TAP1_EXP, cst_pkg::TAP2_EXP, cst_pkg::TAP3_EXP};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), (i >= 2 && i <= 5) ? 32'hFF : 32'h0);
		@(negedge clk);
		`CHK("reset pins", 3'b110, obs)
		apb(1'b0, 8'h1C, 8'h00, {1'b1, 32'h0});
		apb(1'b1, 8'hFC, 8'h55, {1'b1, 32'h0});
		$display("test registers done");
		wr(cst_pkg::PERIOD_LO_OFS, 8'h02);
		wr(cst_pkg::PERIOD_HI_OFS, 8'h00);
		for (int t = 0; t < 4; t++) for (int p = 0; p < 2; p++) begin
			wr(cst_pkg::LOWER_CTRL_OFS, {4'h0, p[0], 1'b0, t[1:0]});
			wr(cst_pkg::UPPER_CTRL_OFS, 8'h08);
			waitv(0, 1'b1);
			t0 = t1;
			waitv(0, 1'b1);
			`CHK("irq gap", 2 << (taps[t] + p), t1 - t0)
			wr(cst_pkg::UPPER_CTRL_OFS, 8'h00);
		end
		$display("test timer done");
		wr(cst_pkg::PERIOD_LO_OFS, 8'h03);
		wr(cst_pkg::PERIOD_HI_OFS, 8'h00);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h09);
		irq_cnt = 0;
		repeat (10) begin
			repeat (2 + ($random(seed) & 3)) @(posedge clk);
			ev_pin <= 1'b0;
			repeat (2 + ($random(seed) & 3)) @(posedge clk);
			ev_pin <= 1'b1;
		end
		repeat (4) @(posedge clk);
		`CHK("event irqs", 3, irq_cnt)
		rd(cst_pkg::COUNT_OFS, 32'h1);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h00);
		$display("test event done");
		wr(cst_pkg::LOWER_CTRL_OFS, 8'h03);
		wr(cst_pkg::DUTY_LO_OFS, 8'h03);
		wr(cst_pkg::DUTY_HI_OFS, 8'h00);
		rd(cst_pkg::DUTY_LO_OFS, 32'h03);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h0A);
		waitv(1, 1'b0);
		wr(cst_pkg::DUTY_LO_OFS, 8'h05);
		rd(cst_pkg::DUTY_LO_OFS, 32'h03);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h02);
		@(negedge clk);
		`CHK("stopped pins", 3'b100, obs)
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h02);
		@(negedge clk);
		`CHK("preset low", 3'b110, obs)
		wr(cst_pkg::DUTY_LO_OFS, 8'h07);
		rd(cst_pkg::DUTY_LO_OFS, 32'h07);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h8A);
		@(negedge clk);
		`CHK("preset high", 3'b100, obs)
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h02);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h00);
		$display("test pwm done");
		wr(cst_pkg::DUTY_LO_OFS, 8'h02);
		wr(cst_pkg::DUTY_HI_OFS, 8'h00);
		wr(cst_pkg::PERIOD_LO_OFS, 8'h04);
		wr(cst_pkg::PERIOD_HI_OFS, 8'h00);
		wr(cst_pkg::UPPER_CTRL_OFS, 8'h0B);
		waitv(2, 1'b0);
		t0 = t1;
		waitv(0, 1'b1);
		`CHK("ppg width", 16, t1 - t0)
		`CHK("ppg end pins", 3'b111, obs)
		$display("test ppg done");
		report_and_stop();
	end
endmodule
